// >>> asb_map.svh
// Purpose: timing and field constants for the byte-wide static memory host
// Assumes: 25 MHz system clock, fastest memory speed grade
// Notes: all nanosecond figures are converted to clock cycles by rounding up
// Operation
// (RULE1) wait one millisecond after power before access
// (RULE2) write happens while select and strobe low
// (RULE3) write ends at first rising select/strobe
// (RULE4) data stable 7 ns before write end
// (RULE5) hold data until write end edge
// (RULE6) address setup, hold and 12 ns cycle
// (RULE7) strobe write with enable low: 6+7 ns
// (RULE8) strobe stays high during every read
// (RULE9) read data valid 12 ns after address
// (RULE10) old data held 3 ns after address change
// (RULE11) address valid no later than select falls
// (RULE12) enable high means memory bus floats
// (RULE13) joint select/strobe rise keeps bus floating
// (RULE14) host does not drive while memory drives
// (RULE15) deselect before retention, recover one read cycle
// (RULE16) read: select and enable low, strobe high
// (RULE17) memory floats when deselected, disabled or writing
// (RULE18) round nanosecond limits up to whole cycles
`ifndef ASB_MAP_SVH
`define ASB_MAP_SVH
`define ASB_CLK_NS 40
`define ASB_POWER_UP_WAIT_NS 1000000
`define ASB_READ_CYCLE_TIME_NS 12
`define ASB_ADDRESS_ACCESS_TIME_NS 12
`define ASB_WRITE_CYCLE_TIME_NS 12
`define ASB_ADDRESS_SETUP_TO_END_NS 10
`define ASB_WRITE_DATA_SETUP_NS 7
`define ASB_STROBE_LOW_TO_FLOAT_NS 6
`define ASB_RETENTION_RECOVERY_NS `ASB_READ_CYCLE_TIME_NS
`define ASB_CYC(ns) (((ns) + `ASB_CLK_NS - 1) / `ASB_CLK_NS)
`define ASB_ADDR_W 19
`define ASB_DATA_W 8
`define ASB_CNT_W 16
`define ASB_STROBE_NS (`ASB_STROBE_LOW_TO_FLOAT_NS + `ASB_WRITE_DATA_SETUP_NS)
`endif

// >>> asb_pkg.sv
// Purpose: types shared by the static memory host modules
// Assumes: asb_map.svh supplies widths
// Notes: none
`include "asb_map.svh"
package asb_pkg;
  typedef enum logic [2:0] {
    ASB_POWERUP, ASB_IDLE, ASB_READ, ASB_WRITE, ASB_GAP, ASB_RETAIN,
    ASB_RECOVER
  } asb_state_e;
  typedef logic [`ASB_CNT_W-1:0] asb_cnt_t;
endpackage

// >>> asb_tmr_if.sv
// Purpose: load/expire link between sequencer and its cycle timer
// Assumes: single clock
// Notes: none
`timescale 1ns/1ns
interface asb_tmr_if;
  logic load;
  asb_pkg::asb_cnt_t value;
  logic done;
  modport ctl (output load, output value, input done);
  modport tmr (input load, input value, output done);
endinterface

// >>> asb_timer.sv
// Purpose: down counter that times the read, write and recovery phases
// Assumes: load value is at least one
// Notes: done is high while count is zero and no load is pending
`timescale 1ns/1ns
`include "asb_map.svh"
module asb_timer (
  input wire logic clk,
  input wire logic sys_rst,
  asb_tmr_if.tmr t
);
  asb_pkg::asb_cnt_t cnt_q;
  // -----------------------------------------------------------------
  // count down
  // -----------------------------------------------------------------
  // count loaded minus one so a load of n gives done n edges later
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_q <= '0;
    end else if (t.load) begin
      cnt_q <= t.value - `ASB_CNT_W'(1);
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - `ASB_CNT_W'(1);
    end
  end
  assign t.done = (cnt_q == '0) && !t.load;
endmodule // asb_timer

// >>> asb_host.sv
// Purpose: host controller driving an asynchronous byte-wide static memory
// Assumes: memory pins sampled synchronously, fastest speed grade fitted
// Notes: one access at a time; req_ready shows when a request is taken
`timescale 1ns/1ns
`include "asb_map.svh"
module asb_host #(
  parameter int POWER_UP_CYCLES = `ASB_CYC(`ASB_POWER_UP_WAIT_NS)
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [`ASB_ADDR_W-1:0] req_addr,
  input wire logic [`ASB_DATA_W-1:0] req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic [`ASB_DATA_W-1:0] rsp_rdata,
  input wire logic retain_req,
  output logic retain_ok,
  output logic [`ASB_ADDR_W-1:0] mem_addr,
  output logic chip_select_n,
  output logic output_enable_n,
  output logic write_strobe_n,
  input wire logic [`ASB_DATA_W-1:0] mem_data_i,
  output logic [`ASB_DATA_W-1:0] mem_data_o,
  output logic mem_data_oe
);
  // cycle counts, rounded up so no limit is undercut [RULE18]
  localparam int RD_CYC = `ASB_CYC(`ASB_ADDRESS_ACCESS_TIME_NS); // [RULE9]
  localparam int WC_CYC = `ASB_CYC(`ASB_WRITE_CYCLE_TIME_NS);
  localparam int AW_CYC = `ASB_CYC(`ASB_ADDRESS_SETUP_TO_END_NS);
  localparam int ST_CYC = `ASB_CYC(`ASB_STROBE_NS); // [RULE7]
  localparam int WR_CYC = (AW_CYC > ST_CYC) ? AW_CYC : ST_CYC;
  localparam int WR_LEN = (WR_CYC > WC_CYC) ? WR_CYC : WC_CYC; // [RULE6]
  localparam int RR_CYC = `ASB_CYC(`ASB_RETENTION_RECOVERY_NS);

  asb_pkg::asb_state_e state_q, state_d;
  logic [`ASB_DATA_W-1:0] rdata_q;
  logic rsp_q;
  logic pwr_load_q;
  logic [`ASB_CNT_W-1:0] pwr_cnt_q;
  asb_tmr_if tm ();

  asb_timer u_timer (
    .clk(clk),
    .sys_rst(sys_rst),
    .t(tm.tmr)
  );

  // -----------------------------------------------------------------
  // decode
  // -----------------------------------------------------------------
  function automatic logic [`ASB_CNT_W-1:0] cyc(input int n);
    cyc = `ASB_CNT_W'(n);
  endfunction
  wire take_w = (state_q == asb_pkg::ASB_IDLE) && req_valid && !retain_req;
  wire pwr_done_w = (pwr_cnt_q == '0);
  wire phase_end_w = tm.done && !pwr_load_q;
  wire in_read_w = (state_q == asb_pkg::ASB_READ);
  wire in_write_w = (state_q == asb_pkg::ASB_WRITE);

  // power-up wait uses its own count, the same ASB_CNT_W width as the phase timer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pwr_cnt_q <= '1;
      pwr_load_q <= 1'b1;
    end else if (pwr_load_q) begin
      pwr_cnt_q <= `ASB_CNT_W'(POWER_UP_CYCLES); // [RULE1]
      pwr_load_q <= 1'b0;
    end else if (!pwr_done_w) begin
      pwr_cnt_q <= pwr_cnt_q - `ASB_CNT_W'(1);
    end
  end

  // -----------------------------------------------------------------
  // sequencer
  // -----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    tm.load = 1'b0;
    tm.value = cyc(1);
    case (state_q)
      asb_pkg::ASB_POWERUP: begin
        if (!pwr_load_q && pwr_done_w) begin
          state_d = asb_pkg::ASB_IDLE; // no access before wait ends [RULE1]
        end
      end
      asb_pkg::ASB_IDLE: begin
        if (retain_req) begin
          state_d = asb_pkg::ASB_RETAIN; // already deselected [RULE15]
        end else if (req_valid && req_write) begin
          state_d = asb_pkg::ASB_WRITE;
          tm.load = 1'b1;
          tm.value = cyc(WR_LEN);
        end else if (req_valid) begin
          state_d = asb_pkg::ASB_READ;
          tm.load = 1'b1;
          tm.value = cyc(RD_CYC);
        end
      end
      asb_pkg::ASB_READ: begin
        if (tm.done) begin
          state_d = asb_pkg::ASB_IDLE;
        end
      end
      asb_pkg::ASB_WRITE: begin
        if (tm.done) begin
          state_d = asb_pkg::ASB_GAP;
        end
      end
      asb_pkg::ASB_GAP: begin
        state_d = asb_pkg::ASB_IDLE;
      end
      asb_pkg::ASB_RETAIN: begin
        if (!retain_req) begin
          state_d = asb_pkg::ASB_RECOVER;
          tm.load = 1'b1;
          tm.value = cyc(RR_CYC); // [RULE15]
        end
      end
      asb_pkg::ASB_RECOVER: begin
        if (tm.done) begin
          state_d = asb_pkg::ASB_IDLE;
        end
      end
      default: begin
        state_d = asb_pkg::ASB_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= asb_pkg::ASB_POWERUP;
    end else begin
      state_q <= state_d;
    end
  end

  // -----------------------------------------------------------------
  // memory pins
  // -----------------------------------------------------------------
  // address moves only when taking a request, on the same edge that
  // select falls, and is held through the write end [RULE11] [RULE6]
  // a write raises select and strobe together; memory never drives
  // because enable stays high during writes [RULE3] [RULE13]
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mem_addr <= '0;
      mem_data_o <= '0;
      mem_data_oe <= 1'b0;
      chip_select_n <= 1'b1;
      output_enable_n <= 1'b1;
      write_strobe_n <= 1'b1;
    end else begin
      if (take_w) begin
        mem_addr <= req_addr;
        mem_data_o <= req_wdata; // stable through whole strobe [RULE4]
      end
      chip_select_n <= !(state_d == asb_pkg::ASB_READ ||
                         state_d == asb_pkg::ASB_WRITE); // [RULE2]
      output_enable_n <= !(state_d == asb_pkg::ASB_READ); // [RULE16]
      write_strobe_n <= !(state_d == asb_pkg::ASB_WRITE); // [RULE8]
      // drive only in write and gap; enable is high there [RULE14] [RULE5]
      mem_data_oe <= (state_d == asb_pkg::ASB_WRITE) ||
                     (state_d == asb_pkg::ASB_GAP);
    end
  end

  // -----------------------------------------------------------------
  // user side
  // -----------------------------------------------------------------
  // data sampled at the last read cycle edge, after access time [RULE9]
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_q <= '0;
      rsp_q <= 1'b0;
      req_ready <= 1'b0;
      retain_ok <= 1'b0;
    end else begin
      rsp_q <= in_read_w && tm.done;
      if (in_read_w && tm.done) begin
        rdata_q <= mem_data_i; // [RULE10]
      end
      req_ready <= (state_d == asb_pkg::ASB_IDLE) && !retain_req;
      retain_ok <= (state_d == asb_pkg::ASB_RETAIN);
    end
  end
  assign rsp_valid = rsp_q;
  assign rsp_rdata = rdata_q;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  sequence s_wr_start;
    !chip_select_n && !write_strobe_n && $fell(write_strobe_n);
  endsequence
  property p_rd_strobe;
    @(posedge clk) disable iff (sys_rst)
      !output_enable_n |-> write_strobe_n;
  endproperty
  a_rd_strobe: assert property (p_rd_strobe) // [RULE8]
    else $error("strobe low during read");
  property p_no_fight;
    @(posedge clk) disable iff (sys_rst)
      mem_data_oe |-> output_enable_n;
  endproperty
  a_no_fight: assert property (p_no_fight) // [RULE14]
    else $error("host drives while memory enabled");
  property p_wr_len;
    @(posedge clk) disable iff (sys_rst)
      s_wr_start |-> (!write_strobe_n && mem_data_oe)[*1] ##1
        write_strobe_n && chip_select_n && $stable(mem_addr) &&
        $stable(mem_data_o);
  endproperty
  a_wr_len: assert property (p_wr_len) // [RULE4]
    else $error("write strobe length or data stability wrong");
  property p_wr_end;
    @(posedge clk) disable iff (sys_rst)
      $rose(write_strobe_n) |-> $rose(chip_select_n) && mem_data_oe;
  endproperty
  a_wr_end: assert property (p_wr_end) // [RULE3]
    else $error("write end not joint or data dropped early");
  property p_addr_hold;
    @(posedge clk) disable iff (sys_rst)
      !chip_select_n && !$fell(chip_select_n) |-> $stable(mem_addr);
  endproperty
  a_addr_hold: assert property (p_addr_hold) // [RULE11]
    else $error("address moved while selected");
  property p_pwr;
    @(posedge clk) disable iff (sys_rst)
      !pwr_done_w || pwr_load_q |-> chip_select_n;
  endproperty
  a_pwr: assert property (p_pwr) // [RULE1]
    else $error("access before power-up wait");
  property p_rd_resp;
    @(posedge clk) disable iff (sys_rst)
      $fell(output_enable_n) |-> ##1 output_enable_n && rsp_valid;
  endproperty
  a_rd_resp: assert property (p_rd_resp) // [RULE9]
    else $error("read response timing wrong");
  property p_retain;
    @(posedge clk) disable iff (sys_rst)
      retain_ok |-> chip_select_n && write_strobe_n;
  endproperty
  a_retain: assert property (p_retain) // [RULE15]
    else $error("selected during retention");
endmodule // asb_host

// >>> asb_mem_model.sv
// Purpose: behavioural byte-wide static memory for the host bench
// Assumes: access delay below one host clock period
// Notes: a released bus shows a flipped value; the next address or read change flips it back to the last byte
`timescale 1ns/1ns
module asb_mem_model #(
  parameter int ACC_NS = 30,
  parameter int HOLD_NS = 3
) (
  input wire logic [18:0] addr,
  input wire logic chip_select_n,
  input wire logic output_enable_n,
  input wire logic write_strobe_n,
  input wire logic [7:0] bus,
  output logic [7:0] rd,
  output logic drv
);
  logic [7:0] mem [logic [18:0]];
  wire logic wr_on = !chip_select_n && !write_strobe_n;
  wire logic rd_on = !chip_select_n && !output_enable_n && write_strobe_n;
  initial begin
    rd = 8'h00;
    drv = 1'b0;
  end
  // store when the first of select or strobe rises
  always @(negedge wr_on) begin
    mem[addr] = bus;
  end
  // answer after the access time; old data is kept HOLD_NS after a change, then the bus floats
  always @(rd_on, addr) begin
    if (drv) begin
      #(HOLD_NS);
    end
    drv = 1'b0;
    rd = ~rd;
    if (rd_on) begin
      #(ACC_NS);
      drv = rd_on;
      rd = mem.exists(addr) ? mem[addr] : 8'h00;
    end
  end
endmodule // asb_mem_model

// >>> tb_async_sram_byte_port.sv
// Purpose: self-checking bench for the static memory host
// Assumes: short power-up count, slow memory model
// Notes: reads are scored in order through a queue
`timescale 1ns/1ns
`include "asb_map.svh"
module tb_async_sram_byte_port;
  localparam int AW = `ASB_ADDR_W;
  logic clk, sys_rst, req_valid, req_write, retain_req, req_ready;
  logic rsp_valid, retain_ok, chip_select_n, output_enable_n;
  logic write_strobe_n, mem_data_oe, drv, wr_q;
  logic [AW-1:0] req_addr, mem_addr, a_q, a;
  logic [7:0] req_wdata, rsp_rdata, mem_data_o, rd, d_q, d;
  wire logic [7:0] bus = mem_data_oe ? mem_data_o : rd;
  int mismatches = 0;
  int compares = 0;
  logic [7:0] exp_q [$];
  logic [7:0] ref_m [logic [AW-1:0]];
  logic [AW-1:0] adr_q [$];
  asb_host #(.POWER_UP_CYCLES(20)) dut (.clk(clk), .sys_rst(sys_rst),
    .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .retain_req(retain_req), .retain_ok(retain_ok),
    .mem_addr(mem_addr), .chip_select_n(chip_select_n),
    .output_enable_n(output_enable_n), .write_strobe_n(write_strobe_n),
    .mem_data_i(bus), .mem_data_o(mem_data_o), .mem_data_oe(mem_data_oe));
  asb_mem_model #(.ACC_NS(30)) mem_u (.addr(mem_addr),
    .chip_select_n(chip_select_n), .output_enable_n(output_enable_n),
    .write_strobe_n(write_strobe_n), .bus(bus), .rd(rd), .drv(drv));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task final_report;
    if (mismatches == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // hold the request until the edge that takes it
  task automatic req(input logic wr, input logic [AW-1:0] ad,
                     input logic [7:0] dt);
    int n;
    n = 0;
    req_valid = 1'b1;
    req_write = wr;
    req_addr = ad;
    req_wdata = dt;
    do begin
      @(posedge clk);
      n++;
    end while (req_ready !== 1'b1 && n < 40);
    chk(n < 40, "request not taken");
    if (!wr) exp_q.push_back(ref_m[ad]);
    #1;
  endtask
  // ----------------------------------------------------------------
  // scoring and pin watch
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (!sys_rst && rsp_valid === 1'b1) begin
      if (exp_q.size() == 0) chk(1'b0, "unexpected read data");
      else chk(rsp_rdata === exp_q.pop_front(), "read data");
    end
  end
  always @(posedge clk) begin
    if (!sys_rst) begin
      if (output_enable_n === 1'b0) chk(write_strobe_n === 1'b1, "we low");
      chk(!(mem_data_oe === 1'b1 && drv === 1'b1), "contention");
      if (!chip_select_n && !write_strobe_n) chk(mem_data_oe === 1'b1 &&
        output_enable_n === 1'b1, "write data");
      if (wr_q) chk(chip_select_n === 1'b1 && write_strobe_n === 1'b1 &&
        mem_data_oe === 1'b1 && mem_data_o === d_q && mem_addr === a_q,
        "write end");
    end
    wr_q <= !chip_select_n && !write_strobe_n;
    a_q <= mem_addr;
    d_q <= mem_data_o;
  end
  initial begin
    #(5000 * 40);
    mismatches++;
    final_report();
  end
  initial begin
    sys_rst = 1'b1;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = '0;
    req_wdata = '0;
    retain_req = 1'b0;
    void'($urandom(31));
    repeat (16) @(posedge clk);
    #1 sys_rst = 1'b0;
    // no access may start inside the power-up wait
    repeat (20) begin
      @(posedge clk);
      chk(chip_select_n === 1'b1 && req_ready === 1'b0, "early");
    end
    #1;
    for (int i = 0; i < 24; i++) begin
      a = (i == 0) ? '0 : (i == 1) ? '1 : AW'($urandom);
      d = 8'($urandom);
      ref_m[a] = d;
      adr_q.push_back(a);
      req(1'b1, a, d);
    end
    foreach (adr_q[i]) req(1'b0, adr_q[i], 8'h00);
    // write then read the same byte back to back
    repeat (6) begin
      a = AW'($urandom);
      d = 8'($urandom);
      ref_m[a] = d;
      req(1'b1, a, d);
      req(1'b0, a, 8'h00);
    end
    // retention with a request pending: memory must stay deselected
    retain_req = 1'b1;
    req_addr = adr_q[0];
    req_write = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk(retain_ok === 1'b1 && chip_select_n === 1'b1, "retain");
    chk(req_ready === 1'b0 && exp_q.size() == 0, "taken in retain");
    retain_req = 1'b0;
    @(posedge clk);
    #1;
    chk(chip_select_n === 1'b1, "no recovery");
    req(1'b0, adr_q[0], 8'h00);
    req_valid = 1'b0;
    repeat (6) @(posedge clk);
    chk(exp_q.size() == 0, "reads missing");
    final_report();
  end
endmodule // tb_async_sram_byte_port
